// ---- hw/srw_pkg.sv ----
// Shared constants and types for the stop recovery and watchdog block.
// Assumes one 250 MHz reference clock that also stands for the crystal.
package srw_pkg;

	// **************************************************
	// Timing
	// **************************************************
	localparam int CLK_PERIOD_NS  = 4;     // Reference clock period
	localparam int TPOR_NS        = 5000;  // Stabilisation delay, in ns
	localparam int TPOR_CYCLES    =
		(TPOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WMODE_WIN_XTAL = 120;   // Mode write window, xtal clks
	localparam int PRESCALE_DIV   = 16;    // Tick prescaler ratio

	// **************************************************
	// Register map
	// **************************************************
	localparam logic [7:0] ADDR_STOP_RECOVERY = 8'h0b;
	localparam logic [7:0] ADDR_WDOG_MODE     = 8'h0f;

	// Stop recovery control field positions
	localparam int SRC_DIV16_BIT = 0;
	localparam int SRC_SRC_LO    = 2;
	localparam int SRC_DELAY_BIT = 5;
	localparam int SRC_POL_BIT   = 6;
	localparam int SRC_WARM_BIT  = 7;

	// Watchdog mode field positions
	localparam int WM_TAP_LO    = 0;
	localparam int WM_HALT_BIT  = 2;
	localparam int WM_STOP_BIT  = 3;

	// Reset values
	localparam logic       RST_DIV16 = 1'b0;
	localparam logic [2:0] RST_SRC   = 3'h0;
	localparam logic       RST_DELAY = 1'b1;
	localparam logic       RST_POL   = 1'b0;
	localparam logic [3:0] RST_WMODE = 4'hd;

	// **************************************************
	// Watchdog counter
	// **************************************************
	localparam int WD_CNT_W = 16;  // Counts RC oscillator ticks
	localparam int DLY_W    = 16;  // Stabilisation counter width
	localparam int WIN_W    = 8;   // Mode write window counter width

	// Wake source selections
	typedef enum logic [2:0] {
		SRC_RESET_ONLY = 3'h0,
		SRC_RESERVED   = 3'h1,
		SRC_P3_BIT1    = 3'h2,
		SRC_P3_BIT2    = 3'h3,
		SRC_P3_BIT3    = 3'h4,
		SRC_P2_BIT7    = 3'h5,
		SRC_NOR_P2_LO  = 3'h6,
		SRC_NOR_P2_ALL = 3'h7
	} srw_src_t;

	// Sequencer states, gray along run, stop, wake, reset
	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_STOP  = 2'b01,
		ST_WAKE  = 2'b11,
		ST_RESET = 2'b10
	} srw_state_t;

	// Asynchronous inputs, synchronised together
	typedef struct packed {
		logic [7:0] port2;
		logic [3:1] port3;
		logic       rc_osc;
		logic       brownout;
		logic       otp_wdog;
	} srw_pins_t;

	// Condition flags driven to the core
	typedef struct packed {
		logic we;
		logic zero;
		logic sign;
		logic overflow;
	} srw_flags_t;

endpackage

// ---- hw/srw_stop_wdog.sv ----
// Stop mode recovery, tick prescaler, watchdog and brown-out sequencer.
// Assumes the core decodes bank F and hands plain register strobes here,
// and that stop, halt and watchdog-instruction signals share ref_clk.
module srw_stop_wdog
	import srw_pkg::*;
#(
	parameter int POR_DELAY_CYCLES = TPOR_CYCLES,
	parameter int WD_TAP0 = 10,  // Counter bit for each timeout tap
	parameter int WD_TAP1 = 11,
	parameter int WD_TAP2 = 12,
	parameter int WD_TAP3 = 14
)
// Functional notes
// - Stop-control bit 0 selects divide-by-16 ticks
// - Stop recovery clears the prescaler bit
// - Three-bit field picks the wake source
// - Port 2 output bits read as zero for wake
// - Delay bit low skips stabilisation delay
// - Polarity bit picks high or low wake
// - Top bit flags warm start after stop
// - Low seven bits write-only, top bit read-only
// - Watchdog one-shot resets core at terminal count
// - First kick enables, later kicks restart count
// - Kick raises the we flag; zero, sign, overflow stay clear
// - Watchdog counts RC oscillator ticks only
// - Mode register: tap, halt run, stop run, reserved
// - Mode writes only in first 120 clocks
// - Mode register reads back as zero
// - Mode register sits at offset 0f
// - Mode bit 3 keeps watchdog running in stop
// - Strap decides watchdog enabled at power-on
// - Brown-out holds reset, then full power-on
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Core handshake, same clock
	input  wire logic       stop_req,
	input  wire logic       halt_mode,
	input  wire logic       wdog_kick,
	input  wire logic [7:0] port2_is_output,
	output logic            core_reset,
	output logic            core_stopped,
	output logic            sys_tick_en,
	output logic            timer_tick_en,
	output srw_flags_t      wdog_flags,
	// Asynchronous pins
	input  wire logic [7:0] wake_port2,
	input  wire logic [3:1] wake_port3,
	input  wire logic       rc_osc,
	input  wire logic       brownout_low,
	input  wire logic       otp_wdog_at_por
);

	// **************************************************
	// Elaboration checks
	// **************************************************
	initial
	begin
		if (POR_DELAY_CYCLES < 1 || POR_DELAY_CYCLES >= (1 << DLY_W))
			$error("POR_DELAY_CYCLES out of range");
		if (WD_TAP3 >= WD_CNT_W || WD_TAP0 < 1)
			$error("Watchdog tap outside counter");
	end

	// **************************************************
	// State
	// **************************************************
	typedef struct packed {
		srw_pins_t           sync1;      // First sync stage only
		srw_pins_t           sync2;      // Usable pin levels
		logic                rc_prev;    // RC edge detector
		srw_state_t          state;      // Sequencer state
		logic                div16;      // Prescaler select
		logic [2:0]          src;        // Wake source select
		logic                delay_en;   // Stabilisation delay enable
		logic                pol;        // Wake polarity
		logic                warm;       // Last start was stop recovery
		logic [3:0]          wmode;      // Watchdog mode, low nibble
		logic                wd_en;      // Watchdog armed
		logic [WD_CNT_W-1:0] wd_cnt;     // Watchdog counter
		logic [3:0]          div_cnt;    // Prescaler counter
		logic [DLY_W-1:0]    dly_cnt;    // Stabilisation counter
		logic [WIN_W-1:0]    win_cnt;    // Mode write window counter
		logic                por_pend;   // Full reset in progress
		logic [7:0]          rdata;
		logic                core_reset;
		logic                core_stopped;
		logic                sys_tick;
		logic                timer_tick;
		srw_flags_t          flags;
	} srw_regs_t;

	srw_regs_t r;
	srw_regs_t next_r;

	// **************************************************
	// Helpers
	// **************************************************
	// Pick the raw wake level for a source selection
	function automatic logic wake_level(input logic [2:0] sel,
		input logic [7:0] p2, input logic [3:1] p3);
		logic l;
		l = 1'b0;
		case (srw_src_t'(sel))
			SRC_P3_BIT1:    l = p3[1];
			SRC_P3_BIT2:    l = p3[2];
			SRC_P3_BIT3:    l = p3[3];
			SRC_P2_BIT7:    l = p2[7];
			SRC_NOR_P2_LO:  l = ~|p2[3:0];
			SRC_NOR_P2_ALL: l = ~|p2;
			default:        l = 1'b0;  // Reset only and reserved
		endcase
		return l;
	endfunction

	// Terminal count reached for the chosen tap
	function automatic logic wd_expired(input logic [1:0] tap,
		input logic [WD_CNT_W-1:0] cnt);
		logic e;
		e = 1'b0;
		case (tap)
			2'd0:    e = cnt[WD_TAP0];
			2'd1:    e = cnt[WD_TAP1];
			2'd2:    e = cnt[WD_TAP2];
			default: e = cnt[WD_TAP3];
		endcase
		return e;
	endfunction

	// **************************************************
	// Combinational next state
	// **************************************************
	// Wake, watchdog and reset sequencing in one pass
	always_comb
	begin
		logic [7:0] p2_eff;
		logic       wake;
		logic       rc_tick;
		logic       wd_run;
		logic       wd_fire;
		logic       go_reset;
		p2_eff   = 8'h00;
		wake     = 1'b0;
		rc_tick  = 1'b0;
		wd_run   = 1'b0;
		wd_fire  = 1'b0;
		go_reset = 1'b0;
		next_r   = r;

		// Two-stage synchroniser on all pins
		next_r.sync1   = {wake_port2, wake_port3, rc_osc,
			brownout_low, otp_wdog_at_por};
		next_r.sync2   = r.sync1;
		next_r.rc_prev = r.sync2.rc_osc;
		next_r.flags   = '{we: 1'b0, zero: 1'b0, sign: 1'b0,
			overflow: 1'b0};

		// Output bits read as zero so only inputs vote
		p2_eff = r.sync2.port2 & ~port2_is_output;
		// Invert by polarity so one high detector serves both
		wake = wake_level(r.src, p2_eff, r.sync2.port3) ^ ~r.pol;
		// Source held short of five processor clocks may be missed
		// since the sync adds two cycles; the source owner holds it.

		// RC oscillator rising edge is the only watchdog clock
		rc_tick = r.sync2.rc_osc & ~r.rc_prev;

		// Watchdog runs in run, in halt if asked, in stop if asked
		case (r.state)
			ST_RUN:  wd_run = ~halt_mode | r.wmode[WM_HALT_BIT];
			ST_STOP: wd_run = r.wmode[WM_STOP_BIT];
			default: wd_run = 1'b0;
		endcase
		wd_fire = r.wd_en & wd_expired(r.wmode[1:0], r.wd_cnt);

		// Watchdog count and kicks
		if (wdog_kick && r.state == ST_RUN)
		begin
			// Kick arms on first use and restarts the count
			next_r.wd_en  = 1'b1;
			next_r.wd_cnt = '0;
			next_r.flags  = '{we: 1'b1, zero: 1'b0, sign: 1'b0,
				overflow: 1'b0};
		end
		else if (r.wd_en && wd_run && rc_tick && !wd_fire)
			next_r.wd_cnt = r.wd_cnt + 1'b1;

		// Tick prescaler, free running
		next_r.div_cnt = r.div_cnt + 1'b1;
		next_r.timer_tick = (r.state == ST_RUN) &&
			(!r.div16 || r.div_cnt == 4'(PRESCALE_DIV - 1));
		next_r.sys_tick = next_r.timer_tick && !halt_mode;

		// Register writes; top stop-control bit is not writable
		if (reg_wr && reg_addr == ADDR_STOP_RECOVERY)
		begin
			next_r.div16    = reg_wdata[SRC_DIV16_BIT];
			next_r.src      = reg_wdata[SRC_SRC_LO +: 3];
			next_r.delay_en = reg_wdata[SRC_DELAY_BIT];
			next_r.pol      = reg_wdata[SRC_POL_BIT];
		end
		// Mode writes close after the window; reserved bits dropped
		if (reg_wr && reg_addr == ADDR_WDOG_MODE &&
			r.state == ST_RUN && r.win_cnt < WIN_W'(WMODE_WIN_XTAL))
			next_r.wmode = reg_wdata[3:0];
		if (r.state == ST_RUN && r.win_cnt < WIN_W'(WMODE_WIN_XTAL))
			next_r.win_cnt = r.win_cnt + 1'b1;

		// Register reads, data in the following cycle
		next_r.rdata = 8'h00;  // Mode and unmapped read zero
		if (reg_rd && reg_addr == ADDR_STOP_RECOVERY)
			next_r.rdata = {r.warm, 7'h00};

		// Full resets: brown-out held, or watchdog timeout
		go_reset = r.sync2.brownout | wd_fire;

		// Sequencer
		case (r.state)
			ST_RUN:
			begin
				if (stop_req)
					next_r.state = ST_STOP;
			end
			ST_STOP:
			begin
				// Recovery clears prescaler and flags a warm start
				if (wake && r.src != SRC_RESET_ONLY &&
					r.src != SRC_RESERVED)
				begin
					next_r.div16   = 1'b0;
					next_r.warm    = 1'b1;
					next_r.wd_cnt  = '0;
					next_r.win_cnt = '0;
					next_r.dly_cnt = '0;
					// Low delay bit gives the fast wake path
					next_r.state = r.delay_en ? ST_WAKE : ST_RUN;
				end
			end
			ST_WAKE:
			begin
				// Stabilisation delay before the core restarts
				next_r.dly_cnt = r.dly_cnt + 1'b1;
				if (r.por_pend)
					next_r.wd_en = r.sync2.otp_wdog;
				if (r.dly_cnt >= DLY_W'(POR_DELAY_CYCLES - 1))
				begin
					next_r.state    = ST_RUN;
					next_r.por_pend = 1'b0;
				end
			end
			ST_RESET:
			begin
				// Held while the supply is low, then power-on path
				if (!r.sync2.brownout)
					next_r.state = ST_WAKE;
			end
			default:
				next_r.state = ST_RESET;
		endcase

		// Full reset restores every control bit to power-on values
		if (go_reset)
		begin
			next_r.state    = ST_RESET;
			next_r.por_pend = 1'b1;
			next_r.div16    = RST_DIV16;
			next_r.src      = RST_SRC;
			next_r.delay_en = RST_DELAY;
			next_r.pol      = RST_POL;
			next_r.warm     = 1'b0;
			next_r.wmode    = RST_WMODE;
			next_r.wd_en    = 1'b0;
			next_r.wd_cnt   = '0;
			next_r.win_cnt  = '0;
			next_r.dly_cnt  = '0;
		end

		// Outputs registered from next state
		next_r.core_reset   = (next_r.state != ST_RUN);
		next_r.core_stopped = (next_r.state == ST_STOP);
	end

	// **************************************************
	// State register
	// **************************************************
	// Asynchronous reset loads constants only; the strap is
	// caught later while the stabilisation delay runs
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r              <= '0;
			r.state        <= ST_WAKE;
			r.por_pend     <= 1'b1;
			r.div16        <= RST_DIV16;
			r.src          <= RST_SRC;
			r.delay_en     <= RST_DELAY;
			r.pol          <= RST_POL;
			r.warm         <= 1'b0;
			r.wmode        <= RST_WMODE;
			r.core_reset   <= 1'b1;
		end
		else
			r <= next_r;
	end

	// **************************************************
	// Outputs, straight from flip-flops
	// **************************************************
	assign reg_rdata     = r.rdata;
	assign core_reset    = r.core_reset;
	assign core_stopped  = r.core_stopped;
	assign sys_tick_en   = r.sys_tick;
	assign timer_tick_en = r.timer_tick;
	assign wdog_flags    = r.flags;

endmodule

// ---- sim/srw_stop_wdog_properties.sv ----
// Port checker for the stop recovery and watchdog block.
// Assumes the sim build uses an eight-cycle stabilisation delay.
module srw_stop_wdog_props
	import srw_pkg::*;
(
	// Clock, reset and register port
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Core side
	input wire logic       wdog_kick,
	input wire logic       core_reset,
	input wire logic       core_stopped,
	input wire srw_flags_t wdog_flags,
	input wire logic       brownout_low
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic       dly; // Shadow of delay select
	logic [2:0] src; // Shadow of wake source
	// Fields are write-only, so keep our own copy
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dly <= 1'b1;
			src <= 3'h0;
		end
		else if (reg_wr && reg_addr == 8'h0b)
		begin
			dly <= reg_wdata[5];
			src <= reg_wdata[4:2];
		end
	end
	a_read_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	a_mode_hidden: assert property (
		$past(reg_rd) && $past(reg_addr) == 8'h0f |-> reg_rdata == 8'h00)
		else $error("mode register readable");
	a_ctrl_lowbits: assert property (
		$past(reg_rd) && $past(reg_addr) == 8'h0b |-> reg_rdata[6:0] == 7'h00)
		else $error("control low bits readable");
	a_kick_flags: assert property (
		wdog_kick && !core_reset |=> wdog_flags == 4'h8)
		else $error("kick flags wrong");
	a_brown_hold: assert property (
		brownout_low [*5] |-> core_reset)
		else $error("core runs in brown-out");
	a_fast_wake: assert property (
		$fell(core_stopped) && !dly |-> !core_reset)
		else $error("fast wake delayed");
	a_slow_wake: assert property (
		$fell(core_stopped) && dly |-> core_reset [*7])
		else $error("stabilisation delay skipped");
	a_reset_only: assert property (
		core_stopped && src <= 3'h1 |=> core_stopped)
		else $error("woke on reset-only source");
	c_fast: cover property ($fell(core_stopped) && !dly);
	c_kick: cover property (wdog_kick && !core_reset);
	c_brown: cover property (brownout_low [*5]);
endmodule
bind srw_stop_wdog srw_stop_wdog_props u_props (.ref_clk, .rst_n,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wdog_kick,
	.core_reset, .core_stopped, .wdog_flags, .brownout_low);

// ---- sim/srw_wake_model.sv ----
// Wake pin sources and the free-running RC oscillator.
// Assumes the bench holds wake_on for as long as wake is wanted.
module srw_wake_model
(
	// Commands from the bench
	input wire logic       ref_clk,
	input wire logic       wake_on,
	input wire logic [2:0] src,
	input wire logic       pol,
	input wire logic       p2_drv0,
	// Pins
	output logic     [7:0] wake_port2,
	output logic     [3:1] wake_port3,
	output logic           rc_osc
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       lvl; // Level of the chosen source
	logic [7:0] p2;
	logic [3:1] p3;
	// Idle pins start inactive for low polarity
	initial
	begin
		rc_osc = 1'b0;
		wake_port2 = 8'hff;
		wake_port3 = 3'h7;
	end
	// RC runs free, unrelated to the crystal
	always #14 rc_osc = ~rc_osc;
	// Held active while asked, at least five periods
	always @(posedge ref_clk)
	begin
		lvl = wake_on ? pol : ~pol;
		p2 = {8{~pol}};
		p3 = {3{~pol}};
		case (src)
		3'h2: p3[1] = lvl;
		3'h3: p3[2] = lvl;
		3'h4: p3[3] = lvl;
		3'h5: p2[7] = lvl;
		// Bit 0 may be an output, driven from p2_drv0 while lvl is high
		3'h6, 3'h7: p2 = lvl ? {7'h00, p2_drv0} : 8'hff;
		default:
		begin
			p2 = {8{lvl}};
			p3 = {3{lvl}};
		end
		endcase
		wake_port2 <= p2;
		wake_port3 <= p3;
	end
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the stop recovery and watchdog block.
// Assumes short sim counts: delay 8, watchdog taps at bits 1 to 4.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [2:0] src;
		logic       pol;
		logic       dly;
		logic       msk;
		logic       fast; // Expected quick release
	} srw_row_t;
	logic       ref_clk, rst_n, reg_wr, reg_rd, stop_req, wdog_kick;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, port2_is_output;
	logic       core_reset, core_stopped, sys_tick_en, brownout_low;
	logic       halt_mode, otp_wdog, timer_tick_en;
	logic [3:0] wdog_flags;
	logic [7:0] wake_port2;
	logic [3:1] wake_port3;
	logic       rc_osc, wake_on, m_pol, m_drv;
	logic [2:0] m_src;
	int         bad_count, num_checks, n, cyc;
	srw_row_t   r;
	srw_row_t   rows [7] = '{7'h29, 7'h34, 7'h4c, 7'h51, 7'h6b, 7'h74,
		7'h79};
	srw_stop_wdog #(.POR_DELAY_CYCLES(8), .WD_TAP0(1), .WD_TAP1(2),
		.WD_TAP2(3), .WD_TAP3(4)) u_dut (.ref_clk, .rst_n, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stop_req,
		.halt_mode, .wdog_kick, .port2_is_output, .core_reset,
		.core_stopped, .sys_tick_en, .timer_tick_en, .wdog_flags,
		.wake_port2, .wake_port3, .rc_osc, .brownout_low,
		.otp_wdog_at_por(otp_wdog));
	srw_wake_model u_wake (.ref_clk, .wake_on, .src(m_src), .pol(m_pol),
		.p2_drv0(m_drv), .wake_port2, .wake_port3, .rc_osc);
	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;
	// Hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			bad_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask
	// Bounded wait for the core reset level
	task automatic wait_rst(input logic v);
		n = 0;
		while (core_reset !== v && n < 400)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk(8'(core_reset), 8'(v));
	endtask
	task automatic ticks(input int len, input logic [7:0] e);
		int c;
		c = 0;
		repeat (len)
		begin
			@(posedge ref_clk);
			#1;
			c += sys_tick_en;
		end
		chk(8'(c), e);
	endtask
	task automatic pulse(input logic k);
		@(posedge ref_clk);
		if (k)
			wdog_kick <= 1'b1;
		else
			stop_req <= 1'b1;
		@(posedge ref_clk);
		wdog_kick <= 1'b0;
		stop_req <= 1'b0;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		{rst_n, reg_wr, reg_rd, stop_req, wdog_kick, wake_on} = 6'h00;
		{reg_addr, reg_wdata, port2_is_output} = 24'h000000;
		{brownout_low, m_pol, m_drv, m_src} = 6'h00;
		{halt_mode, otp_wdog} = 2'h0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		wait_rst(1'b0);
		rd(8'h0b, 8'h00);
		// One stop and wake per row
		for (int i = 0; i < 7; i++)
		begin
			r = rows[i];
			m_src <= r.src;
			m_pol <= r.pol;
			m_drv <= r.msk;
			port2_is_output <= {7'h00, r.msk};
			wr(8'h0b, {1'b0, r.pol, r.dly, r.src, 2'b01});
			ticks(32, 8'h02);
			pulse(1'b0);
			repeat (4) @(posedge ref_clk);
			#1 chk(8'(core_stopped), 8'h01);
			@(posedge ref_clk);
			wake_on <= 1'b1;
			wait_rst(1'b0);
			chk(8'(n < 8), 8'(r.fast));
			@(posedge ref_clk);
			wake_on <= 1'b0;
			rd(8'h0b, 8'h80);
			ticks(16, 8'h10);
		end
		// Reset-only and reserved codes never wake
		for (int s = 0; s < 2; s++)
		begin
			m_src <= 3'(s);
			wr(8'h0b, {3'b011, 3'(s), 2'b00});
			pulse(1'b0);
			@(posedge ref_clk);
			wake_on <= 1'b1;
			repeat (20) @(posedge ref_clk);
			#1 chk(8'(core_stopped), 8'h01);
			@(posedge ref_clk);
			wake_on <= 1'b0;
			rst_n <= 1'b0;
			repeat (3) @(posedge ref_clk);
			rst_n <= 1'b1;
			wait_rst(1'b0);
			rd(8'h0b, 8'h00);
		end
		// Watchdog: longest tap, then a late write that must not land
		wr(8'h0f, 8'h0b);
		rd(8'h0f, 8'h00);
		rd(8'h3c, 8'h00);
		repeat (130) @(posedge ref_clk);
		wr(8'h0f, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			pulse(1'b1);
			repeat (50) @(posedge ref_clk);
			#1 chk(8'(core_reset), 8'h00);
		end
		wait_rst(1'b1);
		chk(8'(n > 45 && n < 85), 8'h01);
		wait_rst(1'b0);
		rd(8'h0b, 8'h00);
		// Brown-out holds reset, then a full restart
		@(posedge ref_clk);
		brownout_low <= 1'b1;
		repeat (20) @(posedge ref_clk);
		#1 chk(8'(core_reset), 8'h01);
		@(posedge ref_clk);
		brownout_low <= 1'b0;
		wait_rst(1'b0);
		// Halt stops the system tick, the timer tick keeps going
		@(posedge ref_clk);
		halt_mode <= 1'b1;
		ticks(16, 8'h00);
		chk(8'(timer_tick_en), 8'h01);
		@(posedge ref_clk);
		halt_mode <= 1'b0;
		// Strap arms the watchdog at power-on with no kick
		otp_wdog <= 1'b1;
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		wait_rst(1'b0);
		wait_rst(1'b1);
		otp_wdog <= 1'b0;
		wait_rst(1'b0);
		// Kick raises the flag strobe one cycle later
		pulse(1'b1);
		#1 chk(8'(wdog_flags), 8'h08);
		end_of_test();
	end
endmodule
